// *** logic/ref_clock_output.sv ***
`timescale 1ns/1ps
module ref_clock_output (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [reference_clock_module_pkg::ADR_W-1:0] adr_i,
  input wire logic [reference_clock_module_pkg::SEL_W-1:0] sel_i,
  input wire logic [reference_clock_module_pkg::DAT_W-1:0] dat_i,
  output logic [reference_clock_module_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // source clocks
  input wire logic sys_osc_clk,
  input wire logic high_freq_internal_osc,
  input wire logic mid_freq_internal_osc,
  input wire logic low_freq_internal_osc,
  input wire logic secondary_osc,
  // power state
  input wire logic sleep_i,
  // reference outputs
  output logic ref_clock_out_pin,
  output logic ref_clock_periph
);
  import reference_clock_module_pkg::*;

  logic [REG_W-1:0] ctrl_q;
  logic [REG_W-1:0] ctrl_d;
  logic [2:0] src_q;
  logic [2:0] src_d;
  logic [DAT_W-1:0] rdata;
  logic req;
  logic wr_ctrl;
  logic wr_src;
  logic [NUM_SRC-1:0] src_async;
  logic [NUM_SRC-1:0] src_sync_q;
  logic lvl;
  logic lvl_q;
  logic rise;
  logic any_edge;
  logic halt;
  logic go_d;
  gen_state_t state_q;
  logic start;
  logic run;
  logic out_q;
  logic written_q;

  // bus request decode
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = req && we_i && sel_i[0] && reg_idx(adr_i) == IDX_CTRL;
  assign wr_src = req && we_i && sel_i[0] && reg_idx(adr_i) == IDX_SRC;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = dat_i[REG_W-1:0] & CTRL_MASK;
    end
  end

  always_comb begin
    src_d = src_q;
    if (wr_src) begin
      src_d = dat_i[SRC_HI:SRC_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      src_q <= SRC_RST;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      src_q <= src_d;
    end
  end

  always_comb begin
    rdata = '0;
    case (reg_idx(adr_i))
      IDX_CTRL: rdata[REG_W-1:0] = ctrl_q;
      IDX_SRC: rdata[SRC_HI:SRC_LO] = src_q;
      IDX_STAT: begin
        rdata[STAT_RUN_BIT] = state_q == GEN_RUN;
        rdata[STAT_OUT_BIT] = out_q;
      end
      default: rdata = '0;
    endcase
  end

  // single-cycle ack, unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (ce) begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= rdata;
      end
    end
  end

  // source selection and edge detection
  assign src_async[SRC_SYS] = sys_osc_clk;
  assign src_async[SRC_HF] = high_freq_internal_osc;
  assign src_async[SRC_LF] = low_freq_internal_osc;
  assign src_async[SRC_MF] = mid_freq_internal_osc;
  assign src_async[SRC_SEC] = secondary_osc;

  src_sync #(
    .W(NUM_SRC)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_i(src_async),
    .sync_o(src_sync_q)
  );

  always_comb begin
    lvl = 1'b0;
    if (src_q <= SRC_SEC) begin
      lvl = src_sync_q[src_q];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
    end else if (ce) begin
      lvl_q <= lvl;
    end
  end

  assign rise = lvl && !lvl_q;
  assign any_edge = lvl ^ lvl_q;

  // sleep stops only the system oscillator source
  assign halt = sleep_i && src_q == SRC_SYS;
  assign go_d = ctrl_d[EN_BIT] && !halt;

  // generator sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= GEN_IDLE;
    end else if (ce) begin
      case (state_q)
        GEN_IDLE: begin
          if (go_d) begin
            state_q <= GEN_ARM;
          end
        end
        GEN_ARM: begin
          if (!go_d) begin
            state_q <= GEN_IDLE;
          end else if (rise) begin
            state_q <= GEN_RUN;
          end
        end
        GEN_RUN: begin
          if (!go_d) begin
            state_q <= GEN_IDLE;
          end
        end
        default: state_q <= GEN_IDLE;
      endcase
    end
  end

  // start on a source rising edge only
  assign start = state_q == GEN_ARM && go_d && rise;
  assign run = state_q == GEN_RUN && go_d;

  ref_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start_i(start),
    .run_i(run),
    .edge_i(any_edge),
    .div_i(ctrl_q[DIV_HI:DIV_LO]),
    .dc_i(ctrl_q[DC_HI:DC_LO]),
    .out_q(out_q)
  );

  assign ref_clock_out_pin = out_q;
  assign ref_clock_periph = out_q;

  // helper: control never written since reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      written_q <= 1'b0;
    end else if (ce && wr_ctrl) begin
      written_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence start_s;
    ce && state_q == GEN_ARM && go_d && rise;
  endsequence

  sequence stop_s;
    ce && wr_ctrl && !dat_i[EN_BIT];
  endsequence

  sequence wr_ctrl_s;
    ce && wr_ctrl;
  endsequence

  sequence wr_src_s;
    ce && wr_src;
  endsequence

  sequence rd_req_s;
    ce && req && !we_i;
  endsequence

  sequence wake_s;
    ce && state_q == GEN_IDLE && go_d;
  endsequence

  duty_reset_a: assert property (!written_q |-> ctrl_q[DC_HI:DC_LO] == DC_50)
    else $error("duty field not at reset value");
  stop_now_a: assert property (stop_s |=> !ref_clock_out_pin)
    else $error("output not stopped at once");
  off_low_a: assert property (!ctrl_q[EN_BIT] |-> !ref_clock_out_pin)
    else $error("disabled output not low");
  clean_start_a: assert property ($rose(ref_clock_out_pin) |-> $past(any_edge))
    else $error("output rose without a source edge");
  start_high_a: assert property ((start_s ##0 ctrl_q[DC_HI:DC_LO] != DC_0) |=>
    (ref_clock_out_pin && state_q == GEN_RUN)) else $error("start did not drive high");
  dc_zero_a: assert property ((start_s ##0 ctrl_q[DC_HI:DC_LO] == DC_0) |=>
    !ref_clock_out_pin) else $error("zero duty start not low");
  periph_same_a: assert property (ref_clock_periph == ref_clock_out_pin)
    else $error("peripheral route differs from pin");
  sleep_stop_a: assert property ((ce && halt) |=>
    (!ref_clock_out_pin && state_q != GEN_RUN)) else $error("system source ran in sleep");
  bad_src_a: assert property (src_q > SRC_SEC |-> !lvl)
    else $error("unimplemented source not quiet");
  ctrl_rsv_a: assert property ((ce && wr_ctrl) |=> ctrl_q[6:5] == 2'h0)
    else $error("reserved control bits stored");
  run_en_a: assert property ((state_q == GEN_RUN) |->
    $past(ctrl_q[EN_BIT]) || ctrl_q[EN_BIT]) else $error("running while disabled");
  ack_one_a: assert property ((ce && req) |=> ack_o ##1 (!ack_o || !ce))
    else $error("ack not a single cycle");

  ctrl_write_a: assert property (wr_ctrl_s |=> ctrl_q == $past(dat_i[REG_W-1:0] & CTRL_MASK))
    else $error("control write not stored");

  src_write_a: assert property (wr_src_s |=> src_q == $past(dat_i[SRC_HI:SRC_LO]))
    else $error("source write not stored");

  rd_ctrl_a: assert property ((rd_req_s ##0 reg_idx(adr_i) == IDX_CTRL) |=>
    dat_o == DAT_W'($past(ctrl_q))) else $error("control read wrong");

  rd_src_a: assert property ((rd_req_s ##0 reg_idx(adr_i) == IDX_SRC) |=>
    dat_o == DAT_W'($past(src_q))) else $error("source read wrong");

  rd_unmapped_a: assert property ((rd_req_s ##0 (reg_idx(adr_i) != IDX_CTRL &&
    reg_idx(adr_i) != IDX_SRC && reg_idx(adr_i) != IDX_STAT)) |=> dat_o == '0)
    else $error("unmapped read not zero");

  wr_blocked_a: assert property ((ce && req && we_i && !sel_i[0]) |=>
    ($stable(ctrl_q) && $stable(src_q))) else $error("lane-less write stored");

  stat_read_a: assert property ((rd_req_s ##0 reg_idx(adr_i) == IDX_STAT) |=>
    dat_o[STAT_OUT_BIT] == $past(out_q)) else $error("status level read wrong");

  arm_go_a: assert property (wake_s |=> state_q == GEN_ARM)
    else $error("enable did not arm");

  idle_stay_a: assert property ((ce && state_q == GEN_IDLE && !go_d) |=>
    state_q == GEN_IDLE) else $error("idle left without enable");

  arm_wait_a: assert property ((ce && state_q == GEN_ARM && go_d && !rise) |=>
    state_q == GEN_ARM) else $error("armed start without source rise");

  arm_quiet_a: assert property ((ce && state_q == GEN_ARM && !start) |=>
    !ref_clock_out_pin) else $error("output moved while armed");

  run_stay_a: assert property ((ce && state_q == GEN_RUN && go_d) |=>
    state_q == GEN_RUN) else $error("generator dropped while enabled");

  sleep_other_a: assert property ((ce && sleep_i && src_q != SRC_SYS &&
    state_q == GEN_RUN && ctrl_d[EN_BIT]) |=> state_q == GEN_RUN)
    else $error("non-system source stopped in sleep");

  start_clear_a: assert property (start_s |=> u_div.cnt_q == '0)
    else $error("start did not clear count");

  idle_cnt_a: assert property ((ce && state_q == GEN_IDLE) |=> u_div.cnt_q == '0)
    else $error("idle count not zero");

  freeze_a: assert property (!ce |=> ($stable(ack_o) && $stable(ctrl_q) &&
    $stable(state_q) && $stable(ref_clock_out_pin))) else $error("state moved while frozen");

  div1_follow_a: assert property ((ce && run && any_edge && !start &&
    ctrl_q[DIV_HI:DIV_LO] == DIV_1 && ctrl_q[DC_HI:DC_LO] != DC_0) |=>
    ref_clock_out_pin == !$past(ref_clock_out_pin)) else $error("undivided output not toggling");

  dc_zero_run_a: assert property ((ce && run && ctrl_q[DC_HI:DC_LO] == DC_0) |=>
    !ref_clock_out_pin) else $error("zero duty output not low");
endmodule

// *** logic/reference_clock_module_pkg.sv ***
package reference_clock_module_pkg;

  localparam int ADR_W = 14;
  localparam int IDX_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 8;
  localparam int CNT_W = 8;
  localparam int NUM_SRC = 5;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'hf39;
  localparam logic [IDX_W-1:0] IDX_SRC = 12'hf3a;
  localparam logic [IDX_W-1:0] IDX_STAT = 12'hf3b;
  localparam int IDX_LSB = 2;

  // control register layout
  localparam int EN_BIT = 7;
  localparam int DC_HI = 4;
  localparam int DC_LO = 3;
  localparam int DIV_HI = 2;
  localparam int DIV_LO = 0;
  localparam logic [REG_W-1:0] CTRL_MASK = 8'h9f;
  localparam logic [REG_W-1:0] CTRL_RST = 8'h10;

  // source select layout
  localparam int SRC_HI = 2;
  localparam int SRC_LO = 0;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [2:0] SRC_SYS = 3'h0;
  localparam logic [2:0] SRC_HF = 3'h1;
  localparam logic [2:0] SRC_LF = 3'h2;
  localparam logic [2:0] SRC_MF = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;

  // status register layout
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_OUT_BIT = 1;

  // duty codes and the undivided ratio code
  localparam logic [1:0] DC_0 = 2'h0;
  localparam logic [1:0] DC_25 = 2'h1;
  localparam logic [1:0] DC_50 = 2'h2;
  localparam logic [1:0] DC_75 = 2'h3;
  localparam logic [2:0] DIV_1 = 3'h0;

  typedef enum logic [1:0] {GEN_IDLE, GEN_ARM, GEN_RUN} gen_state_t;

  // output level for a half-period count, divider and duty code
  function automatic logic shape(input logic [CNT_W-1:0] cnt, input logic [2:0] div,
                                 input logic [1:0] dc);
    logic hi;
    logic lo;
    hi = cnt[div];
    lo = cnt[3'(div - 3'h1)];
    if (dc == DC_0) begin
      shape = 1'b0;
    end else if (div == DIV_1) begin
      shape = ~cnt[0];
    end else begin
      case (dc)
        DC_25: shape = ~hi & ~lo;
        DC_50: shape = ~hi;
        DC_75: shape = ~(hi & lo);
        default: shape = 1'b0;
      endcase
    end
  endfunction

  // register index of a byte address
  function automatic logic [IDX_W-1:0] reg_idx(input logic [ADR_W-1:0] adr);
    reg_idx = adr[ADR_W-1:IDX_LSB];
  endfunction

endpackage

// *** logic/src_sync.sv ***
`timescale 1ns/1ps
module src_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_o <= '0;
    end else if (ce) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** logic/ref_divider.sv ***
`timescale 1ns/1ps
module ref_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic start_i,
  input wire logic run_i,
  input wire logic edge_i,
  input wire logic [2:0] div_i,
  input wire logic [1:0] dc_i,
  // shaped output
  output logic out_q
);
  import reference_clock_module_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign cnt_d = CNT_W'(cnt_q + 1'b1);

  // half-period counter, one step per source edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (start_i || !run_i) begin
        cnt_q <= '0;
      end else if (edge_i) begin
        cnt_q <= cnt_d;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (ce) begin
      if (start_i) begin
        out_q <= shape('0, div_i, dc_i);
      end else if (!run_i) begin
        out_q <= 1'b0;
      end else if (edge_i) begin
        out_q <= shape(cnt_d, div_i, dc_i);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  cnt_step_a: assert property ((ce && run_i && !start_i && edge_i) |=>
    cnt_q == CNT_W'($past(cnt_q) + 1'b1)) else $error("divider count did not step");
  idle_low_a: assert property ((ce && !run_i && !start_i) |=> (!out_q && cnt_q == '0))
    else $error("stopped divider not cleared");
  half_div2_a: assert property ((ce && run_i && edge_i && div_i == 3'h1 && dc_i == DC_50 &&
    cnt_q[1:0] == 2'h1) |=> !out_q) else $error("half duty at ratio two wrong");
endmodule

// *** test/src_model.sv ***
`timescale 1ns/1ps
module src_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // free running oscillators, half period g+3 clk cycles
  output logic [4:0] osc_o
);
  for (genvar g = 0; g < 5; g++) begin : gen_osc
    logic [3:0] cnt_q;
    logic lvl_q;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= 4'h0;
        lvl_q <= 1'b0;
      end else if (cnt_q == 4'(g + 2)) begin
        cnt_q <= 4'h0;
        lvl_q <= ~lvl_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
    assign osc_o[g] = lvl_q;
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  import reference_clock_module_pkg::*;
  logic clk, rst_n, ce, cyc, stb, we, sleep, ack, pin, periph;
  logic [ADR_W-1:0] adr;
  logic [SEL_W-1:0] sel;
  logic [DAT_W-1:0] wdat, rdat, dout;
  logic [4:0] src;
  int errors, samples_checked, seed, i, per, hi;
  logic [2:0] s, d;
  logic [1:0] c;
  logic frz;
  ref_clock_output DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dout), .ack_o(ack),
    .sys_osc_clk(src[0]), .high_freq_internal_osc(src[1]), .low_freq_internal_osc(src[2]),
    .mid_freq_internal_osc(src[3]), .secondary_osc(src[4]), .sleep_i(sleep),
    .ref_clock_out_pin(pin), .ref_clock_periph(periph));
  src_model PM (.clk(clk), .rst_n(rst_n), .osc_o(src));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bail;
    errors++;
    tally_and_finish;
  endtask
  task automatic wb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] v);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'($random(seed)), v};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) bail;
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_level(input logic l);
    int n;
    n = 0;
    while (pin !== l && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) bail;
  endtask
  task automatic measure(output int p, output int h);
    wait_level(1'b0);
    wait_level(1'b1);
    p = 0;
    while (pin === 1'b1 && p < 4000) begin
      @(posedge clk);
      p++;
    end
    h = p;
    while (pin === 1'b0 && p < 4000) begin
      @(posedge clk);
      p++;
    end
    if (p >= 4000) bail;
  endtask
  task automatic check_low(input int n);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge clk);
      h += int'(pin !== 1'b0);
    end
    cmp_cnt(h, 0);
  endtask
  function automatic int exp_per(input logic [2:0] s, input logic [2:0] d);
    return 2 * (int'(s) + 3) * (1 << d);
  endfunction
  function automatic int exp_hi(input logic [2:0] s, input logic [2:0] d, input logic [1:0] c);
    if (c == 2'h0) return 0;
    if (d == 3'h0) return int'(s) + 3;
    return exp_per(s, d) * int'(c) / 4;
  endfunction
  task automatic cfg(input logic [2:0] s, input logic [2:0] d, input logic [1:0] c);
    wb(1'b1, IDX_CTRL, 8'h00);
    wb(1'b1, IDX_SRC, {5'h00, s});
    wb(1'b1, IDX_CTRL, {1'b1, 2'b00, c, d});
    if (s > 3'h4 || c == 2'h0) begin
      check_low(3 * exp_per(3'h4, d));
    end else begin
      repeat (2) begin
        measure(per, hi);
        cmp_cnt(per, exp_per(s, d));
        cmp_cnt(hi, exp_hi(s, d, c));
      end
    end
    wb(1'b0, IDX_STAT, 8'h00);
    cmp_reg(rdat & 32'h1, 32'(s <= 3'h4));
    $display("test src %0d div %0d duty %0d done", s, d, c);
  endtask
  always @(negedge clk) if (rst_n) cmp_reg(32'(periph), 32'(pin));
  initial begin
    seed = 32'h9bf8;
    {cyc, stb, we, sleep, errors, samples_checked} = '0;
    {adr, wdat} = '0;
    sel = 4'hf;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, IDX_CTRL, 8'h00);
    cmp_reg(rdat, 32'h10);
    wb(1'b0, IDX_SRC, 8'h00);
    cmp_reg(rdat, 32'h0);
    wb(1'b1, IDX_CTRL, 8'h7f);
    wb(1'b0, IDX_CTRL, 8'h00);
    cmp_reg(rdat, 32'h1f);
    wb(1'b1, IDX_SRC, 8'hff);
    wb(1'b0, IDX_SRC, 8'h00);
    cmp_reg(rdat, 32'h07);
    wb(1'b0, 12'h100, 8'h00);
    cmp_reg(rdat, 32'h0);
    $display("test registers done");
    cfg(3'h0, 3'h0, 2'h0);
    cfg(3'h1, 3'h0, 2'h1);
    cfg(3'h2, 3'h7, 2'h3);
    cfg(3'h3, 3'h1, 2'h1);
    cfg(3'h5, 3'h2, 2'h2);
    for (i = 0; i < 4; i++) cfg(3'h4, 3'h2, 2'(i));
    for (i = 0; i < 10; i++) cfg(3'($unsigned($random(seed)) % 5), 3'($random(seed)),
      2'($random(seed)));
    cfg(3'h0, 3'h7, 2'h3);
    wait_level(1'b1);
    wb(1'b1, IDX_CTRL, 8'h1f);
    cmp_reg(32'(pin), 32'h0);
    check_low(500);
    $display("test disable done");
    cfg(3'h0, 3'h1, 2'h2);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    check_low(100);
    sleep <= 1'b0;
    measure(per, hi);
    cmp_cnt(hi, exp_hi(3'h0, 3'h1, 2'h2));
    wb(1'b1, IDX_CTRL, 8'h00);
    wb(1'b1, IDX_SRC, 8'h01);
    wb(1'b1, IDX_CTRL, 8'h91);
    sleep <= 1'b1;
    measure(per, hi);
    cmp_cnt(per, exp_per(3'h1, 3'h1));
    sleep <= 1'b0;
    $display("test sleep done");
    ce <= 1'b0;
    @(posedge clk);
    frz = pin;
    hi = 0;
    repeat (40) begin
      @(posedge clk);
      hi += int'(pin !== frz);
    end
    cmp_cnt(hi, 0);
    ce <= 1'b1;
    $display("test clock enable done");
    tally_and_finish;
  end
endmodule
